/* File: core/itc_pkg.sv */
// Constants, register map and vector table of the interrupt controller
//
// Behaviour
// - Seven request sources are arbitrated, each at one of two levels.
// - Each of external pins A and B is level or edge triggered by its own type bit.
// - An edge-type external flag clears when the CPU vectors to it.
// - A level-type external flag follows the low pin and drops on high.
// - Timer A and B overflow flags set on rollover, clear on vectoring.
// - The uart request is rx-done OR tx-done, cleared only by software.
// - The timer C request is overflow OR ext-event, software clears them.
// - With ext-enable set and timer C usable, a falling ext pin edge sets the ext-event flag.
// - The third external input is falling-edge and shares timer C's slot.
// - The i2c request is its interrupt flag, cleared only by software.
// - Software writes set or clear any flag but level-type external ones, and cannot set the i2c one.
// - Enable bit 7 gates all interrupts; individual enables gate each.
// - Enable bits are i2c 6, tc 5, uart 4, tb 3, eb 2, ta 1, ea 0.
// - The priority register uses the enable order with bit 7 reserved.
// - Fixed polling order within a level, each with its own vector.
`default_nettype none
package itc_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_TIMER_CONTROL_REGISTER = 8'h88;
  localparam logic [7:0] ADDR_SCON = 8'h98;
  localparam logic [7:0] ADDR_IE = 8'ha8;
  localparam logic [7:0] ADDR_IP = 8'hb8;
  localparam logic [7:0] ADDR_TIMER_C_CONTROL_REGISTER = 8'hc8;
  localparam logic [7:0] ADDR_I2C_INTERRUPT_REGISTER = 8'hd8;
  localparam logic [7:0] ADDR_STAT = 8'hf0;
  localparam logic [7:0] ADDR_MASK = 8'hf1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Enable and priority bit positions
  localparam int B_GLOBAL = 7;
  localparam int B_I2C = 6;
  localparam int B_TC = 5;
  localparam int B_UART = 4;
  localparam int B_TB = 3;
  localparam int B_EB = 2;
  localparam int B_TA = 1;
  localparam int B_EA = 0;
  // Timer control register bits
  localparam int B_IT0 = 0;
  localparam int B_IE0 = 1;
  localparam int B_IT1 = 2;
  localparam int B_IE1 = 3;
  localparam int B_TF0 = 5;
  localparam int B_TF1 = 7;
  // Timer C control, uart and i2c bits
  localparam int B_TIMER_C_EXT_ENABLE = 3;
  localparam int B_TIMER_C_EXT_EVENT_FLAG = 6;
  localparam int B_TF2 = 7;
  localparam int B_RI = 0;
  localparam int B_TI = 1;
  localparam int B_SI = 7;
  // Polling order index, highest first
  localparam int NSRC = 7;
  localparam logic [2:0] SRC_EXT_A = 3'h0;
  localparam logic [2:0] SRC_TC = 3'h1;
  localparam logic [2:0] SRC_I2C = 3'h2;
  localparam logic [2:0] SRC_TA = 3'h3;
  localparam logic [2:0] SRC_EXT_B = 3'h4;
  localparam logic [2:0] SRC_TB = 3'h5;
  localparam logic [2:0] SRC_UART = 3'h6;
  // Clocks per machine cycle
  localparam int CYCLE_CLKS = 12;
  localparam logic [3:0] CYCLE_LAST = 4'(CYCLE_CLKS - 1);

  // Vector address of a polling index
  function automatic logic [15:0] vec_addr(input logic [2:0] idx);
    case (idx)
      SRC_EXT_A: vec_addr = 16'h0003;
      SRC_TC: vec_addr = 16'h002b;
      SRC_I2C: vec_addr = 16'h0053;
      SRC_TA: vec_addr = 16'h000b;
      SRC_EXT_B: vec_addr = 16'h0013;
      SRC_TB: vec_addr = 16'h001b;
      SRC_UART: vec_addr = 16'h0023;
      default: vec_addr = 16'h0000;
    endcase
  endfunction : vec_addr
endpackage : itc_pkg
`default_nettype wire

/* File: core/itc_tick.sv */
// Machine-cycle enable divider
`default_nettype none
module itc_tick (
  input wire logic clk_i,   // System clock
  input wire logic rst_n_i, // Async reset, active low
  output logic tick_o       // One-cycle pulse per machine cycle
);
  logic [3:0] cnt_ff;

  // Count clocks of one machine cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 4'h0;
    end else if (cnt_ff == itc_pkg::CYCLE_LAST) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  assign tick_o = (cnt_ff == itc_pkg::CYCLE_LAST);
endmodule : itc_tick
`default_nettype wire

/* File: core/itc_pick.sv */
// Fixed-order picker, lowest index wins
`default_nettype none
module itc_pick (
  input wire logic [6:0] req_i, // Requests in polling order
  output logic valid_o,         // Any request present
  output logic [2:0] idx_o      // Winning index
);
  // Scan from lowest priority up so the highest overwrites
  always_comb begin
    valid_o = 1'b0;
    idx_o = 3'h0;
    for (int k = itc_pkg::NSRC - 1; k >= 0; k--) begin
      if (req_i[k]) begin
        valid_o = 1'b1;
        idx_o = 3'(k);
      end
    end
  end
endmodule : itc_pick
`default_nettype wire

/* File: core/itc_ctrl.sv */
// Two-level interrupt controller top
`default_nettype none
module itc_ctrl (
  input wire logic clk_i,                 // System clock, 25 MHz
  input wire logic rst_n_i,               // Async reset, active low
  input wire logic [7:0] addr_i,          // Register address
  input wire logic [7:0] wdata_i,         // Write data
  input wire logic wr_i,                  // Write strobe
  input wire logic rd_i,                  // Read strobe
  output logic [7:0] rdata_o,             // Read data, cycle after strobe
  input wire logic ext_irq_pin_a_n_i,     // External pin A, active low
  input wire logic ext_irq_pin_b_n_i,     // External pin B, active low
  input wire logic timer_c_ext_input_pin_i, // Third external edge input
  input wire logic timer_c_ext_usable_i,  // Timer C free or baud mode
  input wire logic timer_a_rollover_i,    // Timer A rollover pulse
  input wire logic timer_b_rollover_i,    // Timer B rollover pulse
  input wire logic timer_c_rollover_i,    // Timer C rollover pulse
  input wire logic uart_rx_done_i,        // Uart receive complete pulse
  input wire logic uart_tx_done_i,        // Uart transmit complete pulse
  input wire logic i2c_si_set_i,          // I2c interrupt flag set pulse
  input wire logic cpu_ack_i,             // CPU vectors to offered source
  input wire logic cpu_reti_i,            // CPU returns from a routine
  output logic vector_req_o,              // Vector offered to the CPU
  output logic [15:0] vector_addr_o,      // Offered vector address
  output logic irq_o                      // Masked status summary
);
  logic tick;
  logic [7:0] ie_ff;
  logic [7:0] ip_ff;
  logic it0_ff, it1_ff, ie0_ff, ie1_ff, tf0_ff, tf1_ff;
  logic tf2_ff, timer_c_ext_event_flag_ff, timer_c_ext_enable_ff, ri_ff, ti_ff, si_ff;
  logic pin_a_ff, pin_b_ff, pin_c_ff;
  logic fall_a, fall_b, fall_c;
  logic wr_timer_control_register, wr_timer_c_control_register, wr_scon, wr_i2c_interrupt_register;
  logic take, take_idx_hi;
  logic [6:0] flag_poll, en_poll, prio_poll, pend;
  logic hi_valid, lo_valid;
  logic [2:0] hi_idx, lo_idx;
  logic req_ff;
  logic [2:0] src_ff;
  logic lvl_ff;
  logic [15:0] vaddr_ff;
  logic in_hi_ff, in_lo_ff;
  logic [6:0] stat_ff, mask_ff;
  logic [7:0] rdata_ff, nxt_rdata;

  itc_tick u_tick (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tick_o(tick)
  );

  // Write decodes
  assign wr_timer_control_register = wr_i && (addr_i == itc_pkg::ADDR_TIMER_CONTROL_REGISTER);
  assign wr_timer_c_control_register = wr_i && (addr_i == itc_pkg::ADDR_TIMER_C_CONTROL_REGISTER);
  assign wr_scon = wr_i && (addr_i == itc_pkg::ADDR_SCON);
  assign wr_i2c_interrupt_register = wr_i && (addr_i == itc_pkg::ADDR_I2C_INTERRUPT_REGISTER);
  assign take = cpu_ack_i && req_ff;

  // Previous pin levels for falling-edge detection
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_a_ff <= 1'b1;
      pin_b_ff <= 1'b1;
      pin_c_ff <= 1'b1;
    end else begin
      pin_a_ff <= ext_irq_pin_a_n_i;
      pin_b_ff <= ext_irq_pin_b_n_i;
      pin_c_ff <= timer_c_ext_input_pin_i;
    end
  end
  assign fall_a = pin_a_ff && !ext_irq_pin_a_n_i;
  assign fall_b = pin_b_ff && !ext_irq_pin_b_n_i;
  assign fall_c = pin_c_ff && !timer_c_ext_input_pin_i;

  // Enable and priority registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ie_ff <= itc_pkg::RST_BYTE;
      ip_ff <= itc_pkg::RST_BYTE;
    end else begin
      if (wr_i && addr_i == itc_pkg::ADDR_IE) begin
        ie_ff <= wdata_i;
      end
      if (wr_i && addr_i == itc_pkg::ADDR_IP) begin
        ip_ff <= {1'b0, wdata_i[6:0]};
      end
    end
  end

  // External A and B flags: level follows pin, edge is sticky
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      it0_ff <= 1'b0;
      it1_ff <= 1'b0;
      ie0_ff <= 1'b0;
      ie1_ff <= 1'b0;
    end else begin
      if (wr_timer_control_register) begin
        it0_ff <= wdata_i[itc_pkg::B_IT0];
        it1_ff <= wdata_i[itc_pkg::B_IT1];
      end
      if (!it0_ff) begin
        ie0_ff <= !ext_irq_pin_a_n_i;
      end else if (fall_a) begin
        ie0_ff <= 1'b1;
      end else if (wr_timer_control_register) begin
        ie0_ff <= wdata_i[itc_pkg::B_IE0];
      end else if (take && src_ff == itc_pkg::SRC_EXT_A) begin
        ie0_ff <= 1'b0;
      end
      if (!it1_ff) begin
        ie1_ff <= !ext_irq_pin_b_n_i;
      end else if (fall_b) begin
        ie1_ff <= 1'b1;
      end else if (wr_timer_control_register) begin
        ie1_ff <= wdata_i[itc_pkg::B_IE1];
      end else if (take && src_ff == itc_pkg::SRC_EXT_B) begin
        ie1_ff <= 1'b0;
      end
    end
  end

  // Timer A and B overflow flags
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tf0_ff <= 1'b0;
      tf1_ff <= 1'b0;
    end else begin
      if (timer_a_rollover_i) begin
        tf0_ff <= 1'b1;
      end else if (wr_timer_control_register) begin
        tf0_ff <= wdata_i[itc_pkg::B_TF0];
      end else if (take && src_ff == itc_pkg::SRC_TA) begin
        tf0_ff <= 1'b0;
      end
      if (timer_b_rollover_i) begin
        tf1_ff <= 1'b1;
      end else if (wr_timer_control_register) begin
        tf1_ff <= wdata_i[itc_pkg::B_TF1];
      end else if (take && src_ff == itc_pkg::SRC_TB) begin
        tf1_ff <= 1'b0;
      end
    end
  end

  // Timer C flags, never cleared by vectoring
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tf2_ff <= 1'b0;
      timer_c_ext_event_flag_ff <= 1'b0;
      timer_c_ext_enable_ff <= 1'b0;
    end else begin
      if (wr_timer_c_control_register) begin
        timer_c_ext_enable_ff <= wdata_i[itc_pkg::B_TIMER_C_EXT_ENABLE];
      end
      if (timer_c_rollover_i) begin
        tf2_ff <= 1'b1;
      end else if (wr_timer_c_control_register) begin
        tf2_ff <= wdata_i[itc_pkg::B_TF2];
      end
      if (timer_c_ext_enable_ff && fall_c && timer_c_ext_usable_i) begin
        timer_c_ext_event_flag_ff <= 1'b1;
      end else if (wr_timer_c_control_register) begin
        timer_c_ext_event_flag_ff <= wdata_i[itc_pkg::B_TIMER_C_EXT_EVENT_FLAG];
      end
    end
  end

  // Uart and i2c flags, cleared only by software
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ri_ff <= 1'b0;
      ti_ff <= 1'b0;
      si_ff <= 1'b0;
    end else begin
      if (uart_rx_done_i) begin
        ri_ff <= 1'b1;
      end else if (wr_scon) begin
        ri_ff <= wdata_i[itc_pkg::B_RI];
      end
      if (uart_tx_done_i) begin
        ti_ff <= 1'b1;
      end else if (wr_scon) begin
        ti_ff <= wdata_i[itc_pkg::B_TI];
      end
      if (i2c_si_set_i) begin
        si_ff <= 1'b1;
      end else if (wr_i2c_interrupt_register && !wdata_i[itc_pkg::B_SI]) begin
        si_ff <= 1'b0;
      end
    end
  end

  // Requests, enables and levels in polling order
  assign flag_poll = {ri_ff || ti_ff, tf1_ff, ie1_ff, tf0_ff, si_ff,
                      tf2_ff || timer_c_ext_event_flag_ff, ie0_ff};
  assign en_poll = {ie_ff[itc_pkg::B_UART], ie_ff[itc_pkg::B_TB],
                    ie_ff[itc_pkg::B_EB], ie_ff[itc_pkg::B_TA],
                    ie_ff[itc_pkg::B_I2C], ie_ff[itc_pkg::B_TC],
                    ie_ff[itc_pkg::B_EA]};
  assign prio_poll = {ip_ff[itc_pkg::B_UART], ip_ff[itc_pkg::B_TB],
                      ip_ff[itc_pkg::B_EB], ip_ff[itc_pkg::B_TA],
                      ip_ff[itc_pkg::B_I2C], ip_ff[itc_pkg::B_TC],
                      ip_ff[itc_pkg::B_EA]};
  assign pend = flag_poll & en_poll
              & {7{ie_ff[itc_pkg::B_GLOBAL]}};

  // One picker per priority level
  itc_pick u_pick_hi (
    .req_i(pend & prio_poll),
    .valid_o(hi_valid),
    .idx_o(hi_idx)
  );
  itc_pick u_pick_lo (
    .req_i(pend & ~prio_poll),
    .valid_o(lo_valid),
    .idx_o(lo_idx)
  );
  assign take_idx_hi = hi_valid && !in_hi_ff;

  // Offer a vector, re-evaluated once per machine cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_ff <= 1'b0;
      src_ff <= 3'h0;
      lvl_ff <= 1'b0;
      vaddr_ff <= 16'h0000;
    end else if (take) begin
      req_ff <= 1'b0;
    end else if (tick) begin
      if (take_idx_hi) begin
        req_ff <= 1'b1;
        src_ff <= hi_idx;
        lvl_ff <= 1'b1;
        vaddr_ff <= itc_pkg::vec_addr(hi_idx);
      end else if (lo_valid && !in_hi_ff && !in_lo_ff) begin
        req_ff <= 1'b1;
        src_ff <= lo_idx;
        lvl_ff <= 1'b0;
        vaddr_ff <= itc_pkg::vec_addr(lo_idx);
      end else begin
        req_ff <= 1'b0;
      end
    end
  end
  assign vector_req_o = req_ff;
  assign vector_addr_o = vaddr_ff;

  // Routines in service, one per level
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_hi_ff <= 1'b0;
      in_lo_ff <= 1'b0;
    end else if (take) begin
      if (lvl_ff) begin
        in_hi_ff <= 1'b1;
      end else begin
        in_lo_ff <= 1'b1;
      end
    end else if (cpu_reti_i) begin
      if (in_hi_ff) begin
        in_hi_ff <= 1'b0;
      end else begin
        in_lo_ff <= 1'b0;
      end
    end
  end

  // Sticky per-source accept status, write one to clear, set wins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_ff <= 7'h00;
      mask_ff <= 7'h00;
    end else begin
      if (wr_i && addr_i == itc_pkg::ADDR_MASK) begin
        mask_ff <= wdata_i[6:0];
      end
      for (int k = 0; k < itc_pkg::NSRC; k++) begin
        if (take && src_ff == 3'(k)) begin
          stat_ff[k] <= 1'b1;
        end else if (wr_i && addr_i == itc_pkg::ADDR_STAT && wdata_i[k]) begin
          stat_ff[k] <= 1'b0;
        end
      end
    end
  end
  assign irq_o = |(stat_ff & mask_ff);

  // Read mux, data valid only the cycle after the strobe
  always_comb begin
    nxt_rdata = 8'h00;
    case (addr_i)
      itc_pkg::ADDR_IE: nxt_rdata = ie_ff;
      itc_pkg::ADDR_IP: nxt_rdata = ip_ff;
      itc_pkg::ADDR_TIMER_CONTROL_REGISTER: begin
        nxt_rdata[itc_pkg::B_IT0] = it0_ff;
        nxt_rdata[itc_pkg::B_IE0] = ie0_ff;
        nxt_rdata[itc_pkg::B_IT1] = it1_ff;
        nxt_rdata[itc_pkg::B_IE1] = ie1_ff;
        nxt_rdata[itc_pkg::B_TF0] = tf0_ff;
        nxt_rdata[itc_pkg::B_TF1] = tf1_ff;
      end
      itc_pkg::ADDR_TIMER_C_CONTROL_REGISTER: begin
        nxt_rdata[itc_pkg::B_TIMER_C_EXT_ENABLE] = timer_c_ext_enable_ff;
        nxt_rdata[itc_pkg::B_TIMER_C_EXT_EVENT_FLAG] = timer_c_ext_event_flag_ff;
        nxt_rdata[itc_pkg::B_TF2] = tf2_ff;
      end
      itc_pkg::ADDR_SCON: begin
        nxt_rdata[itc_pkg::B_RI] = ri_ff;
        nxt_rdata[itc_pkg::B_TI] = ti_ff;
      end
      itc_pkg::ADDR_I2C_INTERRUPT_REGISTER: nxt_rdata[itc_pkg::B_SI] = si_ff;
      itc_pkg::ADDR_STAT: nxt_rdata = {1'b0, stat_ff};
      itc_pkg::ADDR_MASK: nxt_rdata = {1'b0, mask_ff};
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 8'h00;
    end else if (rd_i) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 8'h00;
    end
  end
  assign rdata_o = rdata_ff;

  // Checks on the arbitration and flags
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_global_gate: assert property (
    tick && !take && !ie_ff[itc_pkg::B_GLOBAL] |=> !vector_req_o)
    else $error("vector offered with global enable off");
  chk_edge_autoclear: assert property (
    take && src_ff == itc_pkg::SRC_EXT_A && it0_ff && !fall_a && !wr_timer_control_register
    |=> !ie0_ff)
    else $error("edge flag not cleared on vectoring");
  chk_level_follow: assert property (
    !it0_ff |=> ie0_ff == !$past(ext_irq_pin_a_n_i))
    else $error("level flag does not follow pin");
  chk_timer_autoclear: assert property (
    take && src_ff == itc_pkg::SRC_TA && !timer_a_rollover_i && !wr_timer_control_register
    |=> !tf0_ff)
    else $error("timer flag not cleared on vectoring");
  chk_uart_kept: assert property (
    take && ri_ff && !wr_scon |=> ri_ff)
    else $error("uart flag cleared by hardware");
  chk_ext_event_set: assert property (
    timer_c_ext_enable_ff && fall_c && timer_c_ext_usable_i |=> timer_c_ext_event_flag_ff)
    else $error("ext event flag not set on falling edge");
  chk_i2c_no_set: assert property (
    wr_i2c_interrupt_register && !si_ff && !i2c_si_set_i |=> !si_ff)
    else $error("software set the i2c flag");
  chk_vector_match: assert property (
    vector_req_o |-> vector_addr_o == itc_pkg::vec_addr(src_ff))
    else $error("vector address does not match source");
  chk_no_nesting: assert property (
    vector_req_o && !lvl_ff |-> !in_hi_ff && !in_lo_ff)
    else $error("low request offered during a routine");
  chk_sample_tick: assert property (
    $rose(vector_req_o) |-> $past(tick))
    else $error("vector offered off the machine cycle");
endmodule : itc_ctrl
`default_nettype wire

/* File: dv/itc_cpu_model.sv */
// Behavioural CPU core that takes offered vectors and returns from routines
`default_nettype none
module itc_cpu_model (
  input wire logic clk_i,           // System clock
  input wire logic rst_n_i,         // Async reset, active low
  input wire logic vector_req_i,    // Vector offered by the controller
  input wire logic [1:0] ack_dly_i, // Extra cycles before taking a vector
  input wire logic reti_cmd_i,      // Return request from the bench
  output logic cpu_ack_o,           // Vector taken, one-cycle pulse
  output logic cpu_reti_o           // Return from routine, one-cycle pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_ff;
  // Take an offered vector after the chosen delay, one pulse per offer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_ack_o <= 1'b0;
      wait_ff <= 2'h0;
    end else if (cpu_ack_o || !vector_req_i) begin
      cpu_ack_o <= 1'b0;
      wait_ff <= 2'h0;
    end else if (wait_ff == ack_dly_i) begin
      cpu_ack_o <= 1'b1;
    end else begin
      wait_ff <= wait_ff + 2'h1;
    end
  end
  // Return from the innermost routine when the bench asks
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_reti_o <= 1'b0;
    end else begin
      cpu_reti_o <= reti_cmd_i;
    end
  end
endmodule : itc_cpu_model
`default_nettype wire

/* File: dv/tb_two_level_interrupt_controller.sv */
// Self-checking bench of the two-level interrupt controller
`default_nettype none
module tb_two_level_interrupt_controller;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) check(n, 16'(e), 16'(g))
  logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic pin_a_n = 1'b1, pin_b_n = 1'b1, pin_c = 1'b1, c_usable = 1'b0;
  logic reti_cmd = 1'b0, cpu_ack, cpu_reti, vector_req, irq;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata, rv, fm;
  logic [5:0] pv = 6'h00;
  logic [15:0] vaddr, got;
  logic [1:0] ack_dly = 2'h0;
  logic [6:0] ip_rand;
  int err_total = 0, num_checks = 0, cyc = 0;
  int ord[$];
  // Vector, enable bit, flag register, flag mask by polling index
  logic [15:0] vtab [7] = '{16'h0003, 16'h002b, 16'h0053, 16'h000b,
                            16'h0013, 16'h001b, 16'h0023};
  int ebit [7] = '{0, 5, 6, 1, 2, 3, 4};
  logic [7:0] fadr [7] = '{8'h88, 8'hc8, 8'hd8, 8'h88, 8'h88, 8'h88, 8'h98};
  logic [7:0] fmsk [7] = '{8'h02, 8'h80, 8'h80, 8'h20, 8'h08, 8'h80, 8'h03};
  bit hwclr [7] = '{1, 0, 0, 1, 1, 1, 0};
  logic [7:0] radr [9] = '{8'h88, 8'h98, 8'ha8, 8'hb8, 8'hc8, 8'hd8,
                           8'hf0, 8'hf1, 8'h00};

  itc_ctrl uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
    .ext_irq_pin_a_n_i(pin_a_n), .ext_irq_pin_b_n_i(pin_b_n),
    .timer_c_ext_input_pin_i(pin_c), .timer_c_ext_usable_i(c_usable),
    .timer_a_rollover_i(pv[0]), .timer_b_rollover_i(pv[1]),
    .timer_c_rollover_i(pv[2]), .uart_rx_done_i(pv[3]),
    .uart_tx_done_i(pv[4]), .i2c_si_set_i(pv[5]), .cpu_ack_i(cpu_ack),
    .cpu_reti_i(cpu_reti), .vector_req_o(vector_req),
    .vector_addr_o(vaddr), .irq_o(irq)
  );
  itc_cpu_model cpu (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .vector_req_i(vector_req),
    .ack_dly_i(ack_dly), .reti_cmd_i(reti_cmd), .cpu_ack_o(cpu_ack),
    .cpu_reti_o(cpu_reti)
  );

  task automatic check(string n, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic conclude();
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  // One-cycle register write
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // One-cycle register read, data sampled in the following cycle
  task automatic rd(logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    rv = rdata;
  endtask : rd
  // One-cycle event pulses on the source inputs
  task automatic pls(logic [5:0] m);
    @(posedge clk_i);
    pv <= m;
    @(posedge clk_i);
    pv <= 6'h00;
  endtask : pls
  // Address of the vector the core takes, unknown on time-out
  task automatic take_vec();
    got = 16'hxxxx;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_i);
      if (cpu_ack === 1'b1) begin
        got = vaddr;
        break;
      end
    end
  endtask : take_vec
  // Count the cycles in which a vector is offered
  task automatic quiet(int n);
    got = 16'h0000;
    repeat (n) begin
      @(negedge clk_i);
      if (vector_req !== 1'b0) got++;
    end
  endtask : quiet
  task automatic reti();
    @(posedge clk_i);
    reti_cmd <= 1'b1;
    @(posedge clk_i);
    reti_cmd <= 1'b0;
  endtask : reti

  // 25 MHz clock
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // Cut a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    void'($urandom(63));
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // Reset values, unmapped place reads zero
    foreach (radr[i]) begin
      rd(radr[i]);
      `CHK("reset_value", 8'h00, rv);
    end
    wr(8'ha8, 8'h7f);
    rd(8'ha8);
    `CHK("enable_mask", 8'h7f, rv);
    // Read data stand for one cycle only, then fall back to zero
    @(negedge clk_i);
    `CHK("rdata_idle", 8'h00, rdata);
    wr(8'hb8, 8'hff);
    rd(8'hb8);
    `CHK("priority_sel", 8'h7f, rv);
    // Software set and clear of flags, i2c flag cannot be set
    wr(8'hd8, 8'h80);
    rd(8'hd8);
    `CHK("i2c_sw_set", 8'h00, rv);
    wr(8'h88, 8'ha0);
    rd(8'h88);
    `CHK("timer_control_register_sw_set", 8'ha0, rv);
    wr(8'h88, 8'h05);
    rd(8'h88);
    `CHK("timer_control_register_sw_clr", 8'h05, rv);
    // All seven pending at random levels, global gate off first
    ip_rand = 7'($urandom());
    ack_dly = 2'($urandom());
    wr(8'hb8, {1'b0, ip_rand});
    pls(6'h3f);
    pin_a_n <= 1'b0;
    pin_b_n <= 1'b0;
    quiet(30);
    `CHK("global_off", 0, got);
    wr(8'ha8, 8'hff);
    for (int lv = 1; lv >= 0; lv--) begin
      for (int i = 0; i < 7; i++) begin
        if (ip_rand[ebit[i]] == lv) ord.push_back(i);
      end
    end
    foreach (ord[k]) begin
      take_vec();
      `CHK("vector", vtab[ord[k]], got);
      rd(fadr[ord[k]]);
      fm = fmsk[ord[k]];
      `CHK("flag", hwclr[ord[k]] ? 8'h00 : fm, rv & fm);
      if (!hwclr[ord[k]]) wr(fadr[ord[k]], rv & ~fm);
      reti();
    end
    pin_a_n <= 1'b1;
    pin_b_n <= 1'b1;
    // Sticky status, mask and summary output
    rd(8'hf0);
    `CHK("status", 8'h7f, rv);
    wr(8'hf1, 8'h04);
    @(negedge clk_i);
    `CHK("irq_on", 1'b1, irq);
    wr(8'hf0, 8'h04);
    @(negedge clk_i);
    `CHK("irq_off", 1'b0, irq);
    // Low routine: same level waits, high preempts
    wr(8'hb8, 8'h02);
    wr(8'ha8, 8'h8a);
    pls(6'h02);
    take_vec();
    `CHK("low_vec", 16'h001b, got);
    pls(6'h02);
    quiet(30);
    `CHK("same_wait", 0, got);
    pls(6'h01);
    take_vec();
    `CHK("preempt", 16'h000b, got);
    reti();
    quiet(30);
    `CHK("low_busy", 0, got);
    reti();
    take_vec();
    `CHK("low_again", 16'h001b, got);
    reti();
    // Level-type pin A: flag follows pin, kept over vectoring
    wr(8'h88, 8'h00);
    wr(8'ha8, 8'h81);
    pin_a_n <= 1'b0;
    take_vec();
    `CHK("level_vec", 16'h0003, got);
    rd(8'h88);
    `CHK("level_kept", 8'h02, rv & 8'h02);
    @(posedge clk_i);
    pin_a_n <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(8'h88);
    `CHK("level_drop", 8'h00, rv & 8'h02);
    reti();
    // Third input edge with enable held set: needs usable
    wr(8'hc8, 8'h08);
    pin_c <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(8'hc8);
    `CHK("ext_unusable", 8'h08, rv);
    @(posedge clk_i);
    pin_c <= 1'b1;
    c_usable <= 1'b1;
    repeat (3) @(posedge clk_i);
    pin_c <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(8'hc8);
    `CHK("ext_event", 8'h48, rv);
    // The ext-event half of timer C and the tx half of uart each raise their vector alone
    wr(8'ha8, 8'hb0);
    pls(6'h10);
    take_vec();
    `CHK("ext_event_vec", 16'h002b, got);
    wr(8'hc8, 8'h08);
    reti();
    take_vec();
    `CHK("uart_tx_vec", 16'h0023, got);
    wr(8'h98, 8'h00);
    reti();
    quiet(30);
    `CHK("or_cleared", 0, got);
    conclude();
  end
endmodule : tb_two_level_interrupt_controller
`default_nettype wire
